// file: common/ext_irq_defines.svh
// register offsets, field positions and reset values of the external pin interrupt unit
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

`define ADDR_SENSE_CONTROL   4'h0
`define ADDR_ENABLE_MASK     4'h1
`define ADDR_PENDING_FLAGS   4'h2
`define ADDR_CHANGE_CONTROL  4'h3
`define ADDR_CHANGE_FLAGS    4'h4
`define ADDR_CHANGE_MASK_0   4'h5
`define ADDR_CHANGE_MASK_1   4'h6
`define ADDR_CHANGE_MASK_2   4'h7

`define SENSE_ONE_MSB        3
`define SENSE_ONE_LSB        2
`define SENSE_ZERO_MSB       1
`define SENSE_ZERO_LSB       0
`define BIT_PIN_ONE          1
`define BIT_PIN_ZERO         0

`define SENSE_RESET          4'h0
`define ENABLE_RESET         2'h0
`define MASK_RESET           8'h00
`define MASK_ONE_USED        8'h7F

`endif

// file: common/ext_irq_pkg.sv
// types of the external pin interrupt unit
package ext_irq_pkg;
	typedef enum logic [1:0] {
		SENSE_LOW,
		SENSE_ANY,
		SENSE_FALL,
		SENSE_RISE
	} sense_mode_t;
endpackage

// file: sim/external_pin_interrupt_unit_test.sv
// self-checking testbench of the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defines.svh"
module external_pin_interrupt_unit_test;
	logic        clk_in;
	logic        reset_n_in;
	logic [3:0]  addr_in;
	logic [7:0]  wdata_in;
	logic        write_in;
	logic        read_in;
	logic [7:0]  rdata_out;
	logic        pin_zero;
	logic        pin_one;
	logic [23:0] change;
	logic        global_enable_in;
	logic [4:0]  service_ack_in;
	logic [4:0]  request_out;
	logic        wake_out;
	int          num_errors;
	int          tests_run;

	pin_source_model u_src (.clk_in(clk_in), .pin_zero_out(pin_zero), .pin_one_out(pin_one), .change_out(change));

	external_pin_interrupt_unit u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
		.ext_pin_zero_in(pin_zero), .ext_pin_one_in(pin_one), .change_inputs_in(change),
		.global_enable_in(global_enable_in), .service_ack_in(service_ack_in),
		.request_out(request_out), .wake_out(wake_out));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_req(input logic [4:0] exp);
		tests_run++;
		if (request_out !== exp) begin
			num_errors++;
			$display("unexpected request_out: expected %h seen %h", exp, request_out);
		end
	endtask

	task automatic check_wake(input logic exp);
		tests_run++;
		if (wake_out !== exp) begin
			num_errors++;
			$display("unexpected wake_out: expected %h seen %h", exp, wake_out);
		end
	endtask

	// vector-taken pulse, one cycle
	task automatic ack(input logic [4:0] v);
		@(posedge clk_in);
		service_ack_in <= v;
		@(posedge clk_in);
		service_ack_in <= 5'h00;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge clk_in);
		write_in <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr_in <= a;
		read_in <= 1'b1;
		@(posedge clk_in);
		read_in <= 1'b0;
		@(negedge clk_in);
		check_reg("rdata_out", exp, rdata_out);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic reg_defaults();
		for (int a = 0; a < 8; a++)
			rd(a[3:0], 8'h00);
		wr(`ADDR_SENSE_CONTROL, 8'hFF);
		rd(`ADDR_SENSE_CONTROL, 8'h0F);
		wr(`ADDR_ENABLE_MASK, 8'hFF);
		rd(`ADDR_ENABLE_MASK, 8'h03);
		wr(`ADDR_CHANGE_MASK_1, 8'hFF);
		rd(`ADDR_CHANGE_MASK_1, 8'h7F);
		wr(4'h8, 8'hFF);
		rd(4'h8, 8'h00);
	endtask

	task automatic edge_step(input logic [7:0] sense, input logic one, input logic lvl, input logic [1:0] exp);
		wr(`ADDR_SENSE_CONTROL, sense);
		u_src.drive(one ? pin_zero : lvl, one ? lvl : pin_one, change);
		rd(`ADDR_PENDING_FLAGS, {6'h00, exp});
		check_req({3'b000, exp});
		wr(`ADDR_PENDING_FLAGS, 8'h03);
		rd(`ADDR_PENDING_FLAGS, 8'h00);
	endtask

	// each pin, modes any/fall/rise, a falling then a rising step
	task automatic edge_modes();
		@(posedge clk_in);
		global_enable_in <= 1'b1;
		for (int p = 0; p < 2; p++)
			for (int m = 1; m < 4; m++)
				for (int l = 0; l < 2; l++)
					edge_step(8'(m << (2 * p)), p[0], l[0], 2'(((l != 0 ? m : m ^ (m >> 1)) & 1) << p));
	endtask

	task automatic service_clear();
		wr(`ADDR_SENSE_CONTROL, 8'h0A);
		u_src.drive(1'b0, 1'b0, change);
		@(negedge clk_in);
		check_req(5'h03);
		ack(5'h03);
		rd(`ADDR_PENDING_FLAGS, 8'h00);
		u_src.drive(1'b1, 1'b1, change);
	endtask

	task automatic level_mode();
		wr(`ADDR_SENSE_CONTROL, 8'h00);
		u_src.drive(1'b0, 1'b0, change);
		@(negedge clk_in);
		check_req(5'h03);
		check_wake(1'b1);
		rd(`ADDR_PENDING_FLAGS, 8'h00);
		@(posedge clk_in);
		global_enable_in <= 1'b0;
		@(negedge clk_in);
		check_req(5'h00);
		@(posedge clk_in);
		global_enable_in <= 1'b1;
		wr(`ADDR_ENABLE_MASK, 8'h01);
		@(negedge clk_in);
		check_req(5'h01);
		u_src.drive(1'b1, 1'b1, change);
		@(negedge clk_in);
		check_req(5'h00);
		check_wake(1'b0);
	endtask

	task automatic pin_change();
		wr(`ADDR_CHANGE_CONTROL, 8'h07);
		wr(`ADDR_CHANGE_MASK_0, 8'h01);
		wr(`ADDR_CHANGE_MASK_1, 8'h01);
		wr(`ADDR_CHANGE_MASK_2, 8'h80);
		u_src.drive(pin_zero, pin_one, 24'h7F_FEFE);
		rd(`ADDR_CHANGE_FLAGS, 8'h00);
		u_src.drive(pin_zero, pin_one, 24'hFF_FFFF);
		rd(`ADDR_CHANGE_FLAGS, 8'h07);
		check_req(5'h1C);
		wr(`ADDR_CHANGE_FLAGS, 8'h07);
		rd(`ADDR_CHANGE_FLAGS, 8'h00);
		u_src.drive(pin_zero, pin_one, 24'h7F_FEFE);
		@(negedge clk_in);
		check_req(5'h1C);
		ack(5'h1C);
		rd(`ADDR_CHANGE_FLAGS, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		num_errors       = 0;
		tests_run        = 0;
		reset_n_in       = 1'b0;
		addr_in          = 4'h0;
		wdata_in         = 8'h00;
		write_in         = 1'b0;
		read_in          = 1'b0;
		global_enable_in = 1'b0;
		service_ack_in   = 5'h00;
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		reg_defaults();
		edge_modes();
		service_clear();
		level_mode();
		pin_change();
		close_out();
	end

	// whole run needs well under 2000 clocks
	initial begin
		#1_000_000;
		num_errors++;
		close_out();
	end
endmodule
`default_nettype wire

// file: sim/pin_source_model.sv
// model of the circuitry driving the external and pin-change inputs
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
	input  wire logic        clk_in,        // core clock
	output logic             pin_zero_out,  // external pin zero level
	output logic             pin_one_out,   // external pin one level
	output logic [23:0]      change_out     // pin-change input levels
);
	initial begin
		pin_zero_out = 1'b1;
		pin_one_out  = 1'b1;
		change_out   = 24'h00_0000;
	end

	////////////////////////////////////////////////////////////////
	// new levels launched after an edge, held three clocks
	task automatic drive(input logic zero, input logic one, input logic [23:0] change);
		@(posedge clk_in);
		pin_zero_out <= zero;
		pin_one_out  <= one;
		change_out   <= change;
		repeat (3) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// file: src/change_group.sv
// pin-change detection for one group of eight inputs
`timescale 1ns/1ps
`default_nettype none
module change_group (
	input  wire logic       clk_in,      // core clock
	input  wire logic       reset_n_in,  // async reset, active low
	input  wire logic [7:0] pins_in,     // change inputs of the group
	input  wire logic [7:0] mask_in,     // per-pin contribution mask
	input  wire logic       clear_in,    // write-one or service clear
	output logic            change_out,  // async change seen, level
	output logic            pending_out  // group flag
);
	typedef struct packed {
		logic [7:0] last;
		logic       pending;
	} grp_state_t;

	grp_state_t state;
	grp_state_t next_state;

	// combinational compare: a change is visible with no clock running
	assign change_out = |((pins_in ^ state.last) & mask_in);

	always_comb begin
		next_state = state;
		next_state.last = pins_in;
		if (change_out)
			next_state.pending = 1'b1;
		else if (clear_in)
			next_state.pending = 1'b0;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			state <= '{last: 8'h00, pending: 1'b0};
		else
			state <= next_state;
	end

	assign pending_out = state.pending;

	masked_ignored_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(!pending_out && ((pins_in ^ state.last) & ~mask_in) != 8'h00
			&& ((pins_in ^ state.last) & mask_in) == 8'h00) |=> !pending_out)
		else $error("masked pin set group flag");
	change_sets_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		change_out |=> pending_out)
		else $error("change did not set group flag");
endmodule
`default_nettype wire

// file: src/ext_pin_detect.sv
// sense detection and pending flag for one external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module ext_pin_detect
	import ext_irq_pkg::*;
(
	input  wire logic        clk_in,        // core clock
	input  wire logic        reset_n_in,    // async reset, active low
	input  wire logic        pin_in,        // external pin level
	input  wire ext_irq_pkg::sense_mode_t mode_in, // sense selection
	input  wire logic        clear_in,      // write-one or service clear
	output logic             level_req_out, // low level present
	output logic             pending_out    // edge flag
);
	typedef struct packed {
		logic sample;
		logic prev;
		logic pending;
	} det_state_t;

	det_state_t state;
	det_state_t next_state;
	logic       hit;

	always_comb begin
		next_state = state;
		next_state.sample = pin_in;
		next_state.prev = state.sample;
		case (mode_in)
			SENSE_ANY:  hit = state.sample != state.prev;
			SENSE_FALL: hit = state.prev & ~state.sample;
			SENSE_RISE: hit = ~state.prev & state.sample;
			default:    hit = 1'b0;
		endcase
		if (mode_in == SENSE_LOW)
			next_state.pending = 1'b0;
		else if (hit)
			next_state.pending = 1'b1;
		else if (clear_in)
			next_state.pending = 1'b0;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			state <= '{sample: 1'b1, prev: 1'b1, pending: 1'b0};
		else
			state <= next_state;
	end

	// low level reaches the request path directly, without the clock
	assign level_req_out = (mode_in == SENSE_LOW) & ~pin_in;
	assign pending_out = state.pending;

	edge_sets_flag_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(mode_in != SENSE_LOW && hit) |=> pending_out)
		else $error("edge did not set flag");
	level_no_flag_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(mode_in == SENSE_LOW) |=> !pending_out)
		else $error("flag set in level mode");
endmodule
`default_nettype wire

// file: src/external_pin_interrupt_unit.sv
// external pin and pin-change interrupt unit with register port
// How it works
// - pin one sense at bits 3:2
// - pin zero sense at bits 1:0
// - pins sampled; edges over one clock caught
// - low level requests while pin low
// - low level and pin change wake without clock
// - pin-change detection is asynchronous
// - pins trigger even when driven as outputs
// - three groups: 23:16, 14:8, 7:0
// - per-pin mask gates change inputs
// - pin one enable at bit 1
// - pin zero enable at bit 0
// - pin one edge sets flag bit 1
// - pin zero edge sets flag bit 0
// - flag clears on service or write-one
// - level mode keeps flag cleared
// - unused register bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defines.svh"
module external_pin_interrupt_unit (
	input  wire logic        clk_in,            // core clock, 10 MHz
	input  wire logic        reset_n_in,        // async reset, active low
	input  wire logic [3:0]  addr_in,           // register address
	input  wire logic [7:0]  wdata_in,          // write data
	input  wire logic        write_in,          // write strobe
	input  wire logic        read_in,           // read strobe
	output logic      [7:0]  rdata_out,         // read data, cycle after strobe
	input  wire logic        ext_pin_zero_in,   // external pin zero level
	input  wire logic        ext_pin_one_in,    // external pin one level
	input  wire logic [23:0] change_inputs_in,  // pin-change inputs
	input  wire logic        global_enable_in,  // global interrupt bit
	input  wire logic [4:0]  service_ack_in,    // vector taken: g2,g1,g0,one,zero
	output logic [4:0]       request_out,       // requests: g2,g1,g0,one,zero
	output logic             wake_out           // async wake for sleep logic
);
	import ext_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [3:0]  sense;
		logic [1:0]  enable;
		logic [2:0]  group_enable;
		logic [23:0] mask;
		logic [7:0]  rdata;
	} unit_state_t;

	unit_state_t state;
	unit_state_t next_state;

	logic       wr_sense;
	logic       wr_enable;
	logic       wr_flags;
	logic       wr_gctl;
	logic       wr_gflags;
	logic [1:0] ext_clear;
	logic [2:0] grp_clear;
	logic [1:0] ext_level;
	logic [1:0] ext_pending;
	logic [2:0] grp_change;
	logic [2:0] grp_pending;
	logic [1:0] ext_cond;
	logic [4:0] cond;

	assign wr_sense  = write_in && addr_in == `ADDR_SENSE_CONTROL;
	assign wr_enable = write_in && addr_in == `ADDR_ENABLE_MASK;
	assign wr_flags  = write_in && addr_in == `ADDR_PENDING_FLAGS;
	assign wr_gctl   = write_in && addr_in == `ADDR_CHANGE_CONTROL;
	assign wr_gflags = write_in && addr_in == `ADDR_CHANGE_FLAGS;

	// write-one clear or clear on service
	assign ext_clear = (wr_flags ? wdata_in[1:0] : 2'h0) | service_ack_in[1:0];
	assign grp_clear = (wr_gflags ? wdata_in[2:0] : 3'h0) | service_ack_in[4:2];

	////////////////////////////////////////////////////////////////////////
	// pins are read as levels, whatever drives them, so own drive counts too
	ext_pin_detect u_pin_zero (
		.clk_in        (clk_in),
		.reset_n_in    (reset_n_in),
		.pin_in        (ext_pin_zero_in),
		.mode_in       (sense_mode_t'(state.sense[`SENSE_ZERO_MSB:`SENSE_ZERO_LSB])),
		.clear_in      (ext_clear[`BIT_PIN_ZERO]),
		.level_req_out (ext_level[0]),
		.pending_out   (ext_pending[0])
	);

	ext_pin_detect u_pin_one (
		.clk_in        (clk_in),
		.reset_n_in    (reset_n_in),
		.pin_in        (ext_pin_one_in),
		.mode_in       (sense_mode_t'(state.sense[`SENSE_ONE_MSB:`SENSE_ONE_LSB])),
		.clear_in      (ext_clear[`BIT_PIN_ONE]),
		.level_req_out (ext_level[1]),
		.pending_out   (ext_pending[1])
	);

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : grp
			change_group u_group (
				.clk_in      (clk_in),
				.reset_n_in  (reset_n_in),
				.pins_in     (change_inputs_in[g*8 +: 8]),
				.mask_in     (state.mask[g*8 +: 8]),
				.clear_in    (grp_clear[g]),
				.change_out  (grp_change[g]),
				.pending_out (grp_pending[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		if (wr_sense)
			next_state.sense = wdata_in[3:0];
		if (wr_enable)
			next_state.enable = wdata_in[1:0];
		if (wr_gctl)
			next_state.group_enable = wdata_in[2:0];
		if (write_in && addr_in == `ADDR_CHANGE_MASK_0)
			next_state.mask[7:0] = wdata_in;
		if (write_in && addr_in == `ADDR_CHANGE_MASK_1)
			next_state.mask[15:8] = wdata_in & `MASK_ONE_USED;
		if (write_in && addr_in == `ADDR_CHANGE_MASK_2)
			next_state.mask[23:16] = wdata_in;
		next_state.rdata = 8'h00;
		if (read_in) begin
			case (addr_in)
				`ADDR_SENSE_CONTROL:  next_state.rdata = {4'h0, state.sense};
				`ADDR_ENABLE_MASK:    next_state.rdata = {6'h00, state.enable};
				`ADDR_PENDING_FLAGS:  next_state.rdata = {6'h00, ext_pending};
				`ADDR_CHANGE_CONTROL: next_state.rdata = {5'h00, state.group_enable};
				`ADDR_CHANGE_FLAGS:   next_state.rdata = {5'h00, grp_pending};
				`ADDR_CHANGE_MASK_0:  next_state.rdata = state.mask[7:0];
				`ADDR_CHANGE_MASK_1:  next_state.rdata = state.mask[15:8];
				`ADDR_CHANGE_MASK_2:  next_state.rdata = state.mask[23:16];
				default:              next_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			state <= '{sense: `SENSE_RESET, enable: `ENABLE_RESET, group_enable: 3'h0,
				mask: 24'h00_0000, rdata: `MASK_RESET};
		else
			state <= next_state;
	end

	assign rdata_out = state.rdata;

	////////////////////////////////////////////////////////////////////////
	// level mode requests straight from the pin; the source must hold it
	assign ext_cond = ext_pending | ext_level;
	assign cond = {grp_pending, ext_cond};
	assign request_out = cond & {state.group_enable, state.enable} & {5{global_enable_in}};
	// wake path without the clock: level, and asynchronous pin change
	assign wake_out = |(ext_level & state.enable) | |(grp_change & state.group_enable);

	////////////////////////////////////////////////////////////////////////
	sequence write_sense_s;
		wr_sense;
	endsequence
	sequence low_mode_s;
		state.sense[1:0] == 2'b00 && state.enable[0] && global_enable_in && !ext_pin_zero_in;
	endsequence

	sense_store_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		write_sense_s ##1 (read_in && addr_in == `ADDR_SENSE_CONTROL)
		|=> rdata_out == {4'h0, $past(wdata_in[3:0], 2)})
		else $error("sense field not stored");
	level_request_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		low_mode_s |-> request_out[0])
		else $error("level request missing");
	request_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!global_enable_in |-> request_out == 5'h00)
		else $error("request without global bit");
	flags_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		read_in && addr_in == `ADDR_PENDING_FLAGS |=> rdata_out[7:2] == 6'h00)
		else $error("unused flag bits not zero");
	edge_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state.sense[1:0] == 2'b10 ##1 state.sense[1:0] == 2'b10 && $fell(ext_pin_zero_in)
		##1 (state.sense[1:0] == 2'b10 && !ext_clear[0]) |=> ##[0:1] ext_pending[0])
		else $error("falling edge missed");
	service_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		service_ack_in[0] && state.sense[1:0] != 2'b00 && $stable(ext_pin_zero_in)
		&& $past(ext_pin_zero_in, 1) == $past(ext_pin_zero_in, 2) |=> !ext_pending[0])
		else $error("flag not cleared on service");
endmodule
`default_nettype wire
